// *** astc_adc_model.sv ***
// astc_adc_model: converter front end answering each sample strobe
// assumes mux strobes come from astc_top on the same clock
`timescale 1ns/1ps

module astc_adc_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire astc_pkg::astc_mux_t mux_in,
  input wire logic [3:0] lat_in,
  output logic res_valid_out,
  output logic [15:0] res_data_out
);
  logic [3:0] wait_q;
  logic pend_q;
  logic odd_q;
  logic [4:0] ch_q;

  // ****************************************
  // one result per strobe, lat_in + 1 cycles after the strobe is sampled
  // ****************************************
  // odd samples add one so the average lands on a half and must round
  always_ff @(posedge clk_in) begin
    res_valid_out <= 1'b0;
    if (!rst_n_in) begin
      pend_q <= 1'b0;
      odd_q <= 1'b0;
      wait_q <= 4'h0;
      ch_q <= 5'h00;
      res_data_out <= 16'hFFFF;
    end else begin
      if (mux_in.change) begin
        odd_q <= 1'b0;
      end
      if (mux_in.strobe) begin
        pend_q <= 1'b1;
        wait_q <= lat_in;
        ch_q <= mux_in.channel;
      end else if (pend_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (pend_q) begin
        pend_q <= 1'b0;
        odd_q <= ~odd_q;
        res_valid_out <= 1'b1;
        res_data_out <= {3'h0, ch_q, 8'h11} + {15'h0000, odd_q};
      end else begin
        // released data lines: never a stale value
        res_data_out <= ~res_data_out;
      end
    end
  end
endmodule

// *** astc_defines.svh ***
// astc_defines.svh: offsets, field positions, reset values, timing counts
// assumes a 50 MHz clock; included by the package and by every module except astc_adc_model
`ifndef ASTC_DEFINES_SVH
`define ASTC_DEFINES_SVH

// ****************************************
// clock and conversion to cycles
// ****************************************
`define ASTC_CLK_NS 20
// least times: round up to whole cycles
`define ASTC_CYC(ns) (((ns) + `ASTC_CLK_NS - 1) / `ASTC_CLK_NS)
`define ASTC_CNT_W 16

// ****************************************
// register indices, byte address is four times the index
// ****************************************
`define ASTC_IDX_SETTLE 10'h03D
`define ASTC_IDX_CELL 10'h03E
`define ASTC_IDX_AUX 10'h03F
`define ASTC_IDX_CTRL 10'h048
`define ASTC_IDX_STAT 10'h049

// ****************************************
// field positions
// ****************************************
`define ASTC_CELL_DLY 6:4
`define ASTC_AUX_DLY 2:0
`define ASTC_SETTLE_MASK 8'h77
`define ASTC_CELL_IVL 7:4
`define ASTC_TEMP_IVL 3:0
`define ASTC_CTRL_START 0
`define ASTC_CTRL_GROUP 1
`define ASTC_CTRL_OVS 4:2

// ****************************************
// reset values
// ****************************************
`define ASTC_RST_SETTLE 8'h00
`define ASTC_RST_CELL 8'h00
`define ASTC_RST_AUX 32'h0000_0000

// ****************************************
// channels and averaging
// ****************************************
`define ASTC_CH_W 5
`define ASTC_TEMP_CH 5'h10
`define ASTC_AUX_CH0 5'h11
`define ASTC_AUX_LAST 5'h18
`define ASTC_AUX_CNT 8
`define ASTC_OVS_MAX 3'h5
`define ASTC_ACC_W 21

// ****************************************
// settling delays, microseconds
// ****************************************
`define ASTC_DLY_US_0 0
`define ASTC_DLY_US_1 2
`define ASTC_DLY_US_2 5
`define ASTC_DLY_US_3 10
`define ASTC_DLY_US_4 20
`define ASTC_DLY_US_5 50
`define ASTC_DLY_US_6 100
`define ASTC_DLY_US_7 200

// ****************************************
// sampling intervals, nanoseconds
// ****************************************
`define ASTC_IVL_NS_0 4130
`define ASTC_IVL_NS_1 5960
`define ASTC_IVL_NS_2 8020
`define ASTC_IVL_NS_3 10000
`define ASTC_IVL_NS_4 12600
`define ASTC_IVL_NS_5 14900
`define ASTC_IVL_NS_6 17400
`define ASTC_IVL_NS_7 19900
`define ASTC_IVL_NS_8 24900
`define ASTC_IVL_NS_9 30000
`define ASTC_IVL_NS_A 40100
`define ASTC_IVL_NS_B 60000
`define ASTC_IVL_NS_C 100000
`define ASTC_IVL_NS_D 200000
`define ASTC_IVL_NS_E 500000
`define ASTC_IVL_NS_F 1000000

`endif

// *** astc_pkg.sv ***
// astc_pkg: state encoding and output carriers of the sample timer
// assumes astc_defines.svh is on the include path
`include "astc_defines.svh"

package astc_pkg;

  // gray codes along the usual path
  typedef enum logic [2:0] {
    ASTC_IDLE = 3'h0,
    ASTC_SETTLE = 3'h1,
    ASTC_WAIT_IVL = 3'h3,
    ASTC_WAIT_RES = 3'h2,
    ASTC_STORE = 3'h6
  } astc_state_t;

  typedef struct packed {
    logic change;
    logic strobe;
    logic [`ASTC_CH_W-1:0] channel;
  } astc_mux_t;

  typedef struct packed {
    logic valid;
    logic [`ASTC_CH_W-1:0] channel;
    logic [15:0] data;
  } astc_result_t;

endpackage

// *** astc_timer.sv ***
// astc_timer: down counter that times settling delays and intervals
// assumes load_in is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps
`include "astc_defines.svh"

module astc_timer (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic load_in,
  input wire logic [`ASTC_CNT_W-1:0] value_in,
  output logic expired_out
);

  logic [`ASTC_CNT_W-1:0] count_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count_q <= '0;
    end else if (ce_in) begin
      if (load_in) begin
        count_q <= value_in;
      end else if (count_q != '0) begin
        count_q <= count_q - 16'h1;
      end
    end
  end

  // a pending load masks the stale zero of the previous run
  assign expired_out = (count_q == '0) && !load_in;

endmodule

// *** astc_top.sv ***
// astc_top: apb registers and sequencer pacing mux and converter strobes
// assumes converter results arrive on clk_in, one per sample strobe
//
// Contract
// - cell group waits a 3-bit coded delay, 0 to 200 us, after mux change; here only after the first mux change of a request
// - settling delay once per request, never again for oversamples
// - aux group waits a 3-bit coded delay with the same eight steps
// - settle register bits 7 and 3 read zero; software writes zero
// - upper cell register nibble paces every cell conversion
// - lower cell register nibble paces the die temperature channel
// - interval codes 0 to F map to 4.13 up to 1000 us
// - each aux channel has its own nibble, channel 0 on top
// - oversampled conversions are averaged and rounded to 16 bits
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "astc_defines.svh"

module astc_top #(
  parameter logic [15:0] DLY_6_CYC = 16'(`ASTC_CYC(`ASTC_DLY_US_6 * 1000)),
  parameter logic [15:0] DLY_7_CYC = 16'(`ASTC_CYC(`ASTC_DLY_US_7 * 1000)),
  parameter logic [15:0] IVL_C_CYC = 16'(`ASTC_CYC(`ASTC_IVL_NS_C)),
  parameter logic [15:0] IVL_D_CYC = 16'(`ASTC_CYC(`ASTC_IVL_NS_D)),
  parameter logic [15:0] IVL_E_CYC = 16'(`ASTC_CYC(`ASTC_IVL_NS_E)),
  parameter logic [15:0] IVL_F_CYC = 16'(`ASTC_CYC(`ASTC_IVL_NS_F))
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic res_valid_in,
  input wire logic [15:0] res_data_in,
  output astc_pkg::astc_mux_t mux_out,
  output astc_pkg::astc_result_t result_out,
  output logic busy_out
);

  // ****************************************
  // lookup tables
  // ****************************************
  // delay code to cycles
  function automatic logic [15:0] dly_cyc(input logic [2:0] code);
    case (code)
      3'h0: dly_cyc = 16'(`ASTC_CYC(`ASTC_DLY_US_0 * 1000));
      3'h1: dly_cyc = 16'(`ASTC_CYC(`ASTC_DLY_US_1 * 1000));
      3'h2: dly_cyc = 16'(`ASTC_CYC(`ASTC_DLY_US_2 * 1000));
      3'h3: dly_cyc = 16'(`ASTC_CYC(`ASTC_DLY_US_3 * 1000));
      3'h4: dly_cyc = 16'(`ASTC_CYC(`ASTC_DLY_US_4 * 1000));
      3'h5: dly_cyc = 16'(`ASTC_CYC(`ASTC_DLY_US_5 * 1000));
      3'h6: dly_cyc = DLY_6_CYC;
      default: dly_cyc = DLY_7_CYC;
    endcase
  endfunction

  function automatic logic [15:0] ivl_cyc(input logic [3:0] code);
    case (code)
      4'h0: ivl_cyc = 16'(`ASTC_CYC(`ASTC_IVL_NS_0));
      4'h1: ivl_cyc = 16'(`ASTC_CYC(`ASTC_IVL_NS_1));
      4'h2: ivl_cyc = 16'(`ASTC_CYC(`ASTC_IVL_NS_2));
      4'h3: ivl_cyc = 16'(`ASTC_CYC(`ASTC_IVL_NS_3));
      4'h4: ivl_cyc = 16'(`ASTC_CYC(`ASTC_IVL_NS_4));
      4'h5: ivl_cyc = 16'(`ASTC_CYC(`ASTC_IVL_NS_5));
      4'h6: ivl_cyc = 16'(`ASTC_CYC(`ASTC_IVL_NS_6));
      4'h7: ivl_cyc = 16'(`ASTC_CYC(`ASTC_IVL_NS_7));
      4'h8: ivl_cyc = 16'(`ASTC_CYC(`ASTC_IVL_NS_8));
      4'h9: ivl_cyc = 16'(`ASTC_CYC(`ASTC_IVL_NS_9));
      4'hA: ivl_cyc = 16'(`ASTC_CYC(`ASTC_IVL_NS_A));
      4'hB: ivl_cyc = 16'(`ASTC_CYC(`ASTC_IVL_NS_B));
      4'hC: ivl_cyc = IVL_C_CYC;
      4'hD: ivl_cyc = IVL_D_CYC;
      4'hE: ivl_cyc = IVL_E_CYC;
      default: ivl_cyc = IVL_F_CYC;
    endcase
  endfunction

  // average with round half to even
  function automatic logic [15:0] conv_round(
    input logic [`ASTC_ACC_W-1:0] sum,
    input logic [2:0] k
  );
    logic [`ASTC_ACC_W-1:0] q;
    logic [`ASTC_ACC_W-1:0] rem;
    logic [`ASTC_ACC_W-1:0] half;
    logic up;
    q = sum >> k;
    rem = sum & ((21'h1 << k) - 21'h1);
    half = (k == 3'h0) ? 21'h0 : (21'h1 << (k - 3'h1));
    up = (k != 3'h0) && ((rem > half) || ((rem == half) && q[0]));
    conv_round = q[15:0] + {15'h0, up};
  endfunction

  // ****************************************
  // registers and apb slave
  // ****************************************
  logic [7:0] settle_q;
  logic [7:0] cell_q;
  logic [31:0] aux_q;
  logic group_q;
  logic [2:0] ovs_sel_q;
  logic start_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] rd_data;
  logic hit;
  logic [9:0] idx;
  logic setup;
  logic wr;
  astc_pkg::astc_state_t state_q;
  astc_pkg::astc_mux_t mux_q;
  astc_pkg::astc_result_t res_q;
  logic busy_q;

  assign idx = paddr_in[11:2];
  assign setup = psel_in && !penable_in;
  assign wr = psel_in && penable_in && pready_q && pwrite_in;

  always_comb begin
    hit = 1'b1;
    rd_data = 32'h0;
    case (idx)
      `ASTC_IDX_SETTLE: rd_data = {24'h0, settle_q};
      `ASTC_IDX_CELL: rd_data = {24'h0, cell_q};
      `ASTC_IDX_AUX: rd_data = aux_q;
      `ASTC_IDX_CTRL: rd_data = {27'h0, ovs_sel_q, group_q, 1'b0};
      `ASTC_IDX_STAT:
        rd_data = {res_q.data, 3'h0, mux_q.channel, 7'h0, busy_q};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else if (ce_in) begin
      // answer one cycle after setup, so access never waits
      pready_q <= setup;
      pslverr_q <= setup && !hit;
      if (setup) begin
        prdata_q <= pwrite_in ? 32'h0 : rd_data;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      // reset to the recommended no-delay setting
      settle_q <= `ASTC_RST_SETTLE;
      cell_q <= `ASTC_RST_CELL;
      aux_q <= `ASTC_RST_AUX;
      group_q <= 1'b0;
      ovs_sel_q <= 3'h0;
      start_q <= 1'b0;
    end else if (ce_in) begin
      start_q <= 1'b0;
      if (wr) begin
        case (idx)
          `ASTC_IDX_SETTLE: settle_q <= pwdata_in[7:0] & `ASTC_SETTLE_MASK;
          `ASTC_IDX_CELL: cell_q <= pwdata_in[7:0];
          `ASTC_IDX_AUX: aux_q <= pwdata_in;
          `ASTC_IDX_CTRL: begin
            group_q <= pwdata_in[`ASTC_CTRL_GROUP];
            ovs_sel_q <= pwdata_in[`ASTC_CTRL_OVS];
            // a start while busy is ignored
            start_q <= pwdata_in[`ASTC_CTRL_START] && !busy_q;
          end
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // per-channel interval selection
  // ****************************************
  logic [3:0] aux_ch_interval [`ASTC_AUX_CNT];
  genvar gi;
  generate
    for (gi = 0; gi < `ASTC_AUX_CNT; gi++) begin : g_aux
      // channel 0 in the top nibble
      assign aux_ch_interval[gi] = aux_q[31-4*gi -: 4];
    end
  endgenerate

  function automatic logic [3:0] code_of(input logic [4:0] ch);
    logic [4:0] a;
    a = ch - `ASTC_AUX_CH0;
    if (ch < `ASTC_TEMP_CH) begin
      code_of = cell_q[`ASTC_CELL_IVL];
    end else if (ch == `ASTC_TEMP_CH) begin
      code_of = cell_q[`ASTC_TEMP_IVL];
    end else begin
      code_of = aux_ch_interval[a[2:0]];
    end
  endfunction

  // ****************************************
  // sequencer
  // ****************************************
  logic tmr_load_q;
  logic [15:0] tmr_val_q;
  logic tmr_exp;
  logic [2:0] os_k_q;
  logic [4:0] os_cnt_q;
  logic [4:0] os_last;
  logic [`ASTC_ACC_W-1:0] acc_q;
  logic [4:0] nxt_ch;
  logic ch_last;

  assign os_last = 5'((6'h1 << os_k_q) - 6'h1);
  assign nxt_ch = mux_q.channel + 5'h1;
  assign ch_last = (mux_q.channel == `ASTC_TEMP_CH) ||
                   (mux_q.channel == `ASTC_AUX_LAST);

  // one clocked counter times every settling delay and interval
  astc_timer u_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .load_in(tmr_load_q),
    .value_in(tmr_val_q),
    .expired_out(tmr_exp)
  );

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= astc_pkg::ASTC_IDLE;
      mux_q <= '0;
      res_q <= '0;
      busy_q <= 1'b0;
      tmr_load_q <= 1'b0;
      tmr_val_q <= 16'h0;
      os_k_q <= 3'h0;
      os_cnt_q <= 5'h0;
      acc_q <= '0;
    end else if (ce_in) begin
      tmr_load_q <= 1'b0;
      mux_q.change <= 1'b0;
      mux_q.strobe <= 1'b0;
      res_q.valid <= 1'b0;
      case (state_q)
        astc_pkg::ASTC_IDLE: begin
          if (start_q) begin
            busy_q <= 1'b1;
            mux_q.change <= 1'b1;
            mux_q.channel <= group_q ? `ASTC_AUX_CH0 : 5'h0;
            // reserved oversample codes fall back to one sample
            os_k_q <= (ovs_sel_q > `ASTC_OVS_MAX) ? 3'h0 : ovs_sel_q;
            os_cnt_q <= 5'h0;
            acc_q <= '0;
            tmr_load_q <= 1'b1;
            tmr_val_q <= group_q ? dly_cyc(settle_q[`ASTC_AUX_DLY]) :
                                   dly_cyc(settle_q[`ASTC_CELL_DLY]);
            state_q <= astc_pkg::ASTC_SETTLE;
          end
        end
        astc_pkg::ASTC_SETTLE: begin
          if (tmr_exp) begin
            tmr_load_q <= 1'b1;
            tmr_val_q <= ivl_cyc(code_of(mux_q.channel));
            state_q <= astc_pkg::ASTC_WAIT_IVL;
          end
        end
        astc_pkg::ASTC_WAIT_IVL: begin
          if (tmr_exp) begin
            mux_q.strobe <= 1'b1;
            state_q <= astc_pkg::ASTC_WAIT_RES;
          end
        end
        astc_pkg::ASTC_WAIT_RES: begin
          if (res_valid_in) begin
            acc_q <= acc_q + {5'h0, res_data_in};
            if (os_cnt_q == os_last) begin
              state_q <= astc_pkg::ASTC_STORE;
            end else begin
              // oversamples reuse the interval, no settling
              os_cnt_q <= os_cnt_q + 5'h1;
              tmr_load_q <= 1'b1;
              tmr_val_q <= ivl_cyc(code_of(mux_q.channel));
              state_q <= astc_pkg::ASTC_WAIT_IVL;
            end
          end
        end
        astc_pkg::ASTC_STORE: begin
          res_q.valid <= 1'b1;
          res_q.channel <= mux_q.channel;
          res_q.data <= conv_round(acc_q, os_k_q);
          acc_q <= '0;
          os_cnt_q <= 5'h0;
          if (ch_last) begin
            busy_q <= 1'b0;
            state_q <= astc_pkg::ASTC_IDLE;
          end else begin
            mux_q.change <= 1'b1;
            mux_q.channel <= nxt_ch;
            tmr_load_q <= 1'b1;
            tmr_val_q <= ivl_cyc(code_of(nxt_ch));
            state_q <= astc_pkg::ASTC_WAIT_IVL;
          end
        end
        default: state_q <= astc_pkg::ASTC_IDLE;
      endcase
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign mux_out = mux_q;
  assign result_out = res_q;
  assign busy_out = busy_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  cell_settle_a: assert property (
    (ce_in && state_q == astc_pkg::ASTC_IDLE && start_q && !group_q) |=>
    (tmr_load_q && tmr_val_q == dly_cyc(settle_q[`ASTC_CELL_DLY])))
    else $error("cell settling delay not loaded");

  settle_once_a: assert property (
    (state_q == astc_pkg::ASTC_SETTLE) |->
    ($past(state_q) inside {astc_pkg::ASTC_IDLE, astc_pkg::ASTC_SETTLE}))
    else $error("settling entered from mid sequence");

  aux_settle_a: assert property (
    (ce_in && state_q == astc_pkg::ASTC_IDLE && start_q && group_q) |=>
    (tmr_load_q && tmr_val_q == dly_cyc(settle_q[`ASTC_AUX_DLY])))
    else $error("aux settling delay not loaded");

  reserved_zero_a: assert property (
    (pready_out && !pwrite_in && idx == `ASTC_IDX_SETTLE) |->
    (prdata_out[7] == 1'b0 && prdata_out[3] == 1'b0))
    else $error("reserved settle bits read nonzero");

  cell_ivl_a: assert property (
    (tmr_load_q && state_q == astc_pkg::ASTC_WAIT_IVL &&
     mux_q.channel < `ASTC_TEMP_CH) |->
    (tmr_val_q == ivl_cyc(cell_q[`ASTC_CELL_IVL])))
    else $error("cell interval wrong");

  temp_ivl_a: assert property (
    (tmr_load_q && state_q == astc_pkg::ASTC_WAIT_IVL &&
     mux_q.channel == `ASTC_TEMP_CH) |->
    (tmr_val_q == ivl_cyc(cell_q[`ASTC_TEMP_IVL])))
    else $error("die temperature interval wrong");

  aux_ivl_a: assert property (
    (tmr_load_q && state_q == astc_pkg::ASTC_WAIT_IVL &&
     mux_q.channel == `ASTC_AUX_CH0) |->
    (tmr_val_q == ivl_cyc(aux_q[31:28])))
    else $error("aux channel 0 interval wrong");

  avg_count_a: assert property (
    (state_q == astc_pkg::ASTC_STORE) |-> (os_cnt_q == os_last))
    else $error("result stored before all oversamples");

  strobe_wait_a: assert property (
    (mux_q.strobe) |->
    ($past(state_q) == astc_pkg::ASTC_WAIT_IVL && $past(tmr_exp)))
    else $error("sample strobe without expired interval");

  cell_done_c: cover property (res_q.valid &&
    res_q.channel == `ASTC_TEMP_CH);
  aux_done_c: cover property (res_q.valid &&
    res_q.channel == `ASTC_AUX_LAST);
  oversample_c: cover property (res_q.valid && os_k_q == `ASTC_OVS_MAX);

endmodule

// *** tb.sv ***
// tb: register and sequencer checks for astc_top with a converter model
// assumes astc_defines.svh on the include path and a 50 MHz clock
`timescale 1ns/1ps
`include "astc_defines.svh"

module tb;
  localparam int P_D6 = 30, P_D7 = 40, P_IC = 60, P_ID = 70;
  localparam int P_IE = 80, P_IF = 90;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, res_valid, busy, err;
  logic [15:0] res_data;
  logic [3:0] lat = 4'h1;
  logic [7:0] cell_r = 8'h05;
  logic [31:0] aux_r = 32'h0379_CDEF;
  astc_pkg::astc_mux_t mux;
  astc_pkg::astc_result_t res;
  int fails = 0, total_checks = 0, cyc = 0, last_ev = 0;
  logic first_q = 1'b0;
  int rec_ch[$], rec_gap[$], rec_first[$], res_ch[$];
  logic [15:0] res_val[$];
  int ivl_ns[12] = '{4130, 5960, 8020, 10000, 12600, 14900, 17400, 19900,
                     24900, 30000, 40100, 60000};
  int dly_us[6] = '{0, 2, 5, 10, 20, 50};

  always #10 clk_in = ~clk_in;

  // long counts shortened so the run stays brief
  astc_top #(.DLY_6_CYC(16'(P_D6)), .DLY_7_CYC(16'(P_D7)),
    .IVL_C_CYC(16'(P_IC)), .IVL_D_CYC(16'(P_ID)), .IVL_E_CYC(16'(P_IE)),
    .IVL_F_CYC(16'(P_IF))) uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ce_in(1'b1), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .res_valid_in(res_valid),
    .res_data_in(res_data), .mux_out(mux), .result_out(res),
    .busy_out(busy));

  astc_adc_model adc (.clk_in(clk_in), .rst_n_in(rst_n_in), .mux_in(mux),
    .lat_in(lat), .res_valid_out(res_valid), .res_data_out(res_data));

  // ****************************************
  // monitor: gaps from mux change, last result or last strobe
  // ****************************************
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (mux.change) begin
      last_ev <= cyc;
      first_q <= 1'b1;
    end
    // oversample interval runs from the result, not from the strobe
    if (res_valid) begin
      last_ev <= cyc;
    end
    if (mux.strobe) begin
      rec_ch.push_back(int'(mux.channel));
      rec_gap.push_back(cyc - last_ev);
      rec_first.push_back(int'(first_q));
      last_ev <= cyc;
      first_q <= 1'b0;
    end
    if (res.valid) begin
      res_ch.push_back(int'(res.channel));
      res_val.push_back(res.data);
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_in);
    fails++;
    wrap_up();
  end

  // ****************************************
  // apb master and expectations
  // ****************************************
  task automatic xfer(input logic wr, input logic [9:0] idx,
                      input logic [31:0] wd);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    // pready and read data are taken at the rising edge of the access
    do @(posedge clk_in); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask

  function automatic int ivl(input int ch);
    logic [3:0] c;
    c = ch < 16 ? cell_r[7:4] : ch == 16 ? cell_r[3:0] :
        aux_r[31 - 4 * (ch - 17) -: 4];
    case (c)
      4'hC: return P_IC;
      4'hD: return P_ID;
      4'hE: return P_IE;
      4'hF: return P_IF;
      default: return (ivl_ns[c] + 19) / 20;
    endcase
  endfunction

  function automatic int dcyc(input int c);
    return c == 6 ? P_D6 : c == 7 ? P_D7 : dly_us[c] * 50;
  endfunction

  task automatic run(input logic [31:0] ctl);
    int n = 0;
    rec_ch.delete();
    rec_gap.delete();
    rec_first.delete();
    res_ch.delete();
    res_val.delete();
    xfer(1'b1, `ASTC_IDX_CTRL, ctl);
    do @(negedge clk_in); while (busy !== 1'b1 && ++n < 10);
    n = 0;
    do @(negedge clk_in); while (busy !== 1'b0 && ++n < 60000);
    check(32'(n < 60000), 32'h1);
    // last result reaches the monitor one edge after busy falls
    @(negedge clk_in);
    @(posedge clk_in);
  endtask

  task automatic verify(input int ch0, input int nch, input int k,
                        input int dly);
    int lo;
    int ok;
    logic [31:0] exp_v;
    check(32'(rec_ch.size()), 32'(nch << k));
    check(32'(res_ch.size()), 32'(nch));
    foreach (rec_ch[j]) begin
      lo = ivl(rec_ch[j]);
      if (rec_first[j] == 1 && rec_ch[j] == ch0) lo += dly;
      ok = int'(rec_gap[j] >= lo && rec_gap[j] <= lo + 12);
      check(32'(rec_ch[j]), 32'(ch0 + (j >> k)));
      check(32'(ok), 32'h1);
    end
    foreach (res_ch[j]) begin
      // odd samples sit one above, so a tie rounds up to an even value
      exp_v = {19'h0, 5'(ch0 + j), 8'h11} + 32'(k != 0);
      check(32'(res_ch[j]), 32'(ch0 + j));
      check(32'(res_val[j]), exp_v);
    end
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    xfer(1'b0, `ASTC_IDX_SETTLE, 32'h0);
    check(rd, 32'h0000_0000);
    xfer(1'b0, `ASTC_IDX_AUX, 32'h0);
    check(rd, 32'h0000_0000);
    xfer(1'b0, 10'h080, 32'h0);
    check({rd[30:0], err}, 32'h0000_0001);
    xfer(1'b1, `ASTC_IDX_SETTLE, 32'hFFFF_FFFF);
    xfer(1'b0, `ASTC_IDX_SETTLE, 32'h0);
    check(rd, 32'h0000_0077);
    xfer(1'b1, `ASTC_IDX_SETTLE, 32'h0000_0057);
    xfer(1'b1, `ASTC_IDX_CELL, {24'h0, cell_r});
    xfer(1'b1, `ASTC_IDX_AUX, aux_r);
    xfer(1'b0, `ASTC_IDX_CELL, 32'h0);
    check(rd, {24'h0, cell_r});
    xfer(1'b0, `ASTC_IDX_AUX, 32'h0);
    check(rd, aux_r);
    // cell group, two samples each, prompt converter
    run(32'h0000_0005);
    verify(0, 17, 1, dcyc(5));
    xfer(1'b0, `ASTC_IDX_STAT, 32'h0);
    check(rd, 32'h1012_1000);
    // aux group, four samples each, slow converter
    lat <= 4'h9;
    run(32'h0000_000B);
    verify(17, 8, 2, dcyc(7));
    // aux group, reserved oversample code falls back to one sample
    run(32'h0000_001B);
    verify(17, 8, 0, dcyc(7));
    xfer(1'b1, `ASTC_IDX_SETTLE, 32'h0);
    xfer(1'b0, `ASTC_IDX_SETTLE, 32'h0);
    check(rd, 32'h0000_0000);
    wrap_up();
  end
endmodule
